// ==== include/dir_pkg.sv ====
// package: offsets, fields and reset values of the identity, reset and output-state registers
package dir_pkg;
    // register offsets
    localparam logic [7:0] ADDR_OWN_BUS_ADDRESS = 8'h00;
    localparam logic [7:0] ADDR_RESET_AND_BC = 8'h01;
    localparam logic [7:0] ADDR_OUTPUT_STATE = 8'h02;
    // own_bus_address fields
    localparam int OWN_ADDRESS_FIELD_LSB = 1;
    localparam int ADDRESS_SOURCE_SELECT_BIT = 0;
    // reset_and_back_channel fields
    localparam int RETURN_CHANNEL_ON_BIT = 2;
    localparam int FULL_LOGIC_RESET_BIT = 1;
    localparam int LOGIC_ONLY_RESET_BIT = 0;
    // output_state_config fields
    localparam int OUTPUT_ENABLE_BIT = 7;
    localparam int OVERRIDE_BIT = 6;
    localparam int FALLBACK_CLOCK_DRIVE_BIT = 5;
    localparam int SLEEP_STATE_VALUE_BIT = 4;
    // reset values
    localparam logic RST_ADDRESS_SOURCE_SELECT = 1'b0;
    localparam logic RST_RETURN_CHANNEL_ON = 1'b1;
    localparam logic RST_OUTPUT_ENABLE = 1'b0;
    localparam logic RST_OVERRIDE = 1'b0;
    localparam logic RST_FALLBACK_CLOCK_DRIVE = 1'b0;
    localparam logic RST_SLEEP_STATE_VALUE = 1'b0;
    // effective values used when the override is clear
    localparam logic DEFAULT_OUTPUT_ENABLE = 1'b1;
    localparam logic DEFAULT_SLEEP_STATE = 1'b1;
    // length of the internal digital reset pulse, in clock cycles
    localparam logic [2:0] DIGITAL_RESET_CYCLES = 3'h4;
endpackage

// ==== include/dir_wr_if.sv ====
// interface: register write port shared by the bank and the reset sequencer
`timescale 1ns/1ps
interface dir_wr_if;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic from_remote;
    logic full_pulse;
    logic logic_pulse;
    modport bank (input wr_en, input wr_addr, input wr_data, input from_remote,
                  output full_pulse, output logic_pulse);
    modport seq (input full_pulse, input logic_pulse);
endinterface

// ==== hdl/dir_reset_seq.sv ====
// module: stretches a self-clearing reset request into a digital reset pulse
`timescale 1ns/1ps
module dir_reset_seq
    import dir_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    // requests from the register bank
    dir_wr_if.seq wr,
    // stretched reset outputs
    output logic logic_reset_out,
    output logic reload_out
);
    logic [2:0] count_reg;
    logic reload_reg;

    // a fresh request restarts the count, so back-to-back writes merge into one pulse
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            count_reg <= 3'h0;
        end else if (clk_en_in) begin
            if (wr.full_pulse || wr.logic_pulse) begin
                count_reg <= DIGITAL_RESET_CYCLES;
            end else if (count_reg != 3'h0) begin
                count_reg <= count_reg - 3'h1;
            end
        end
    end

    // remember whether the running pulse must also reload the registers
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            reload_reg <= 1'b0;
        end else if (clk_en_in) begin
            if (wr.full_pulse) begin
                reload_reg <= 1'b1;
            end else if (count_reg == 3'h0 && !wr.logic_pulse) begin
                reload_reg <= 1'b0;
            end
        end
    end

    assign logic_reset_out = (count_reg != 3'h0);
    assign reload_out = reload_reg;
endmodule

// ==== hdl/dir_regs.sv ====
// module: identity, reset and output-state registers of the link receiver
`timescale 1ns/1ps
// Operation
// - address field holds own 7-bit bus address, loaded from strap at power-up
// - source bit clear uses strap address, set uses programmed address; power-up and full reset clear
// - return channel enable resets one; remote writes cannot clear it
// - return channel turns off only when enable and both pass-through bits low
// - full reset bit resets all logic and registers, then clears itself
// - full reset reloads strap-derived fields with their strap values
// - logic-only reset resets logic, keeps registers, then clears itself
// - digital reset spares address register, reset bits and excluded fields
// - output enable comes from register only while override set, else one
// - override bit resets zero; one applies programmed enable and sleep values
// - fallback clock bit with link unlocked drives oscillator clock onto pixel clock
// - sleep value with enable sets unlocked output state; default one without override
module dir_regs
    import dir_pkg::*;
(
    // clock, reset and freeze
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    // strap captured at power-up
    input wire logic [6:0] address_strap_input_in,
    // register port, shared by local and remote control paths
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_remote_in,
    output logic [7:0] reg_rdata_out,
    // state of neighbouring registers and the link
    input wire logic pass_through_a_in,
    input wire logic pass_through_b_in,
    input wire logic link_lock_in,
    input wire logic osc_clk_in,
    input wire logic pixel_clk_in,
    // effects on the rest of the device
    output logic [6:0] active_address_out,
    output logic return_channel_active_out,
    output logic logic_reset_out,
    output logic eff_output_enable_out,
    output logic eff_sleep_state_out,
    output logic pixel_clk_sel_osc_out,
    output logic pixel_clk_out
);
    dir_wr_if wr ();

    logic [6:0] strap_reg;
    logic [6:0] own_address_field_reg;
    logic address_source_select_reg;
    logic return_channel_on_reg;
    logic output_enable_reg;
    logic override_reg;
    logic fallback_clock_drive_reg;
    logic sleep_state_value_reg;
    logic full_pulse_reg;
    logic logic_pulse_reg;
    logic seq_reset;
    logic seq_reload;
    logic [7:0] rdata_next;
    logic wr_addr0;
    logic wr_addr1;
    logic wr_addr2;

    assign wr.wr_en = reg_wr_in & clk_en_in;
    assign wr.wr_addr = reg_addr_in;
    assign wr.wr_data = reg_wdata_in;
    assign wr.from_remote = reg_remote_in;
    assign wr.full_pulse = full_pulse_reg;
    assign wr.logic_pulse = logic_pulse_reg;

    // stretches reset requests into the internal digital reset
    dir_reset_seq u_seq (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .clk_en_in(clk_en_in),
        .wr(wr),
        .logic_reset_out(seq_reset),
        .reload_out(seq_reload)
    );

    assign wr_addr0 = wr.wr_en && (wr.wr_addr == ADDR_OWN_BUS_ADDRESS);
    assign wr_addr1 = wr.wr_en && (wr.wr_addr == ADDR_RESET_AND_BC);
    assign wr_addr2 = wr.wr_en && (wr.wr_addr == ADDR_OUTPUT_STATE);

    // strap latched on the power-up reset and kept for later reloads; a full
    // reset restores this original value even if the pins have moved since
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            strap_reg <= address_strap_input_in;
        end
    end

    // address register: loaded from the strap on power-up and full reset
    // a logic-only reset leaves it alone
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            own_address_field_reg <= address_strap_input_in;
            address_source_select_reg <= RST_ADDRESS_SOURCE_SELECT;
        end else if (clk_en_in) begin
            if (seq_reload) begin
                own_address_field_reg <= strap_reg;
                address_source_select_reg <= RST_ADDRESS_SOURCE_SELECT;
            end else if (wr_addr0) begin
                own_address_field_reg <= reg_wdata_in[7:OWN_ADDRESS_FIELD_LSB];
                address_source_select_reg <= reg_wdata_in[ADDRESS_SOURCE_SELECT_BIT];
            end
        end
    end

    // return channel enable; reloaded to one by full reset, kept by logic-only reset, remote may only set it
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            return_channel_on_reg <= RST_RETURN_CHANNEL_ON;
        end else if (clk_en_in) begin
            if (seq_reload) begin
                return_channel_on_reg <= RST_RETURN_CHANNEL_ON;
            end else if (wr_addr1) begin
                if (!wr.from_remote || wr.wr_data[RETURN_CHANNEL_ON_BIT]) begin
                    return_channel_on_reg <= reg_wdata_in[RETURN_CHANNEL_ON_BIT];
                end
            end
        end
    end

    // self-clearing reset bits: one-cycle requests, read back as zero
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            full_pulse_reg <= 1'b0;
            logic_pulse_reg <= 1'b0;
        end else if (clk_en_in) begin
            full_pulse_reg <= wr_addr1 && wr.wr_data[FULL_LOGIC_RESET_BIT];
            logic_pulse_reg <= wr_addr1 && wr.wr_data[LOGIC_ONLY_RESET_BIT];
        end
    end

    // output state config; cleared by full reset, kept by logic-only reset
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            output_enable_reg <= RST_OUTPUT_ENABLE;
            override_reg <= RST_OVERRIDE;
            fallback_clock_drive_reg <= RST_FALLBACK_CLOCK_DRIVE;
            sleep_state_value_reg <= RST_SLEEP_STATE_VALUE;
        end else if (clk_en_in) begin
            if (seq_reload) begin
                output_enable_reg <= RST_OUTPUT_ENABLE;
                override_reg <= RST_OVERRIDE;
                fallback_clock_drive_reg <= RST_FALLBACK_CLOCK_DRIVE;
                sleep_state_value_reg <= RST_SLEEP_STATE_VALUE;
            end else if (wr_addr2) begin
                // software should follow a rising enable with a logic-only reset
                output_enable_reg <= reg_wdata_in[OUTPUT_ENABLE_BIT];
                override_reg <= reg_wdata_in[OVERRIDE_BIT];
                fallback_clock_drive_reg <= reg_wdata_in[FALLBACK_CLOCK_DRIVE_BIT];
                sleep_state_value_reg <= reg_wdata_in[SLEEP_STATE_VALUE_BIT];
            end
        end
    end

    // read mux; reserved bits and self-clearing bits read zero
    always_comb begin
        rdata_next = 8'h00;
        unique case (reg_addr_in)
            ADDR_OWN_BUS_ADDRESS: begin
                rdata_next = {own_address_field_reg, address_source_select_reg};
            end
            ADDR_RESET_AND_BC: begin
                rdata_next[RETURN_CHANNEL_ON_BIT] = return_channel_on_reg;
            end
            ADDR_OUTPUT_STATE: begin
                rdata_next[OUTPUT_ENABLE_BIT] = output_enable_reg;
                rdata_next[OVERRIDE_BIT] = override_reg;
                rdata_next[FALLBACK_CLOCK_DRIVE_BIT] = fallback_clock_drive_reg;
                rdata_next[SLEEP_STATE_VALUE_BIT] = sleep_state_value_reg;
            end
            default: begin
                rdata_next = 8'h00; // unmapped offsets read zero
            end
        endcase
    end

    // registered read data, held between reads
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (clk_en_in && reg_rd_in) begin
            reg_rdata_out <= rdata_next;
        end
    end

    // address in use: strap or programmed value
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            active_address_out <= 7'h00;
        end else if (clk_en_in) begin
            active_address_out <= address_source_select_reg ? own_address_field_reg
                                                            : address_strap_input_in;
        end
    end

    // return channel stays up while either pass-through bit still needs it
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            return_channel_active_out <= RST_RETURN_CHANNEL_ON;
        end else if (clk_en_in) begin
            return_channel_active_out <= return_channel_on_reg
                                         || pass_through_a_in || pass_through_b_in;
        end
    end

    // digital reset to the rest of the device, driven for either reset bit
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            logic_reset_out <= 1'b0;
        end else if (clk_en_in) begin
            logic_reset_out <= seq_reset;
        end
    end

    // effective output enable and sleep state under the override
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            eff_output_enable_out <= DEFAULT_OUTPUT_ENABLE;
            eff_sleep_state_out <= DEFAULT_SLEEP_STATE;
        end else if (clk_en_in) begin
            eff_output_enable_out <= override_reg ? output_enable_reg
                                                  : DEFAULT_OUTPUT_ENABLE;
            eff_sleep_state_out <= override_reg ? sleep_state_value_reg
                                                : DEFAULT_SLEEP_STATE;
        end
    end

    // select the oscillator for the pixel clock while unlocked
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            pixel_clk_sel_osc_out <= 1'b0;
        end else if (clk_en_in) begin
            pixel_clk_sel_osc_out <= fallback_clock_drive_reg && !link_lock_in;
        end
    end

    // the clock value is resampled, so it follows the chosen source at clk_sys rate;
    // a true glitch-free clock mux belongs in the pad ring
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            pixel_clk_out <= 1'b0;
        end else if (clk_en_in) begin
            pixel_clk_out <= pixel_clk_sel_osc_out ? osc_clk_in : pixel_clk_in;
        end
    end
endmodule

// ==== sim/dir_host_model.sv ====
// model: local or remote controller issuing register accesses
`timescale 1ns/1ps
module dir_host_model
    import dir_pkg::*;
(
    // clock and returned data
    input wire logic clk_sys_in,
    input wire logic [7:0] reg_rdata_in,
    // access strobes
    output logic reg_wr_out = 1'b0,
    output logic reg_rd_out = 1'b0,
    output logic [7:0] reg_addr_out = 8'h00,
    output logic [7:0] reg_wdata_out = 8'h00,
    output logic reg_remote_out = 1'b0
);
    // one write; a gap edge follows so back-to-back calls stay apart
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic rem);
        @(negedge clk_sys_in);
        reg_addr_out = a;
        reg_wdata_out = d;
        reg_remote_out = rem;
        reg_wr_out = 1'b1;
        @(negedge clk_sys_in);
        reg_wr_out = 1'b0;
        reg_wdata_out = ~d; // released data must not look valid
        @(negedge clk_sys_in);
    endtask
    // one read; data taken once the registered answer has settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys_in);
        reg_addr_out = a;
        reg_rd_out = 1'b1;
        @(negedge clk_sys_in);
        reg_rd_out = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        d = reg_rdata_in;
    endtask
    // raising the output enable is followed by a logic-only reset
    task automatic raise_oe(input logic [7:0] d);
        wr(ADDR_OUTPUT_STATE, d, 1'b0);
        wr(ADDR_RESET_AND_BC, 8'h05, 1'b0);
    endtask
endmodule

// ==== sim/dir_regs_assertions.sv ====
// checker: port-level properties of the identity, reset and output-state registers
`timescale 1ns/1ps
module dir_regs_assertions
    import dir_pkg::*;
(
    // watched ports
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic [6:0] address_strap_input_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_remote_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic pass_through_a_in,
    input wire logic pass_through_b_in,
    input wire logic link_lock_in,
    input wire logic [6:0] active_address_out,
    input wire logic return_channel_active_out,
    input wire logic logic_reset_out,
    input wire logic eff_output_enable_out,
    input wire logic eff_sleep_state_out,
    input wire logic pixel_clk_sel_osc_out
);
    // a frozen clock enable stalls everything, so checks pause with it
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in || !clk_en_in);
    wire wr0 = reg_wr_in && reg_addr_in == ADDR_OWN_BUS_ADDRESS;
    wire wr1 = reg_wr_in && reg_addr_in == ADDR_RESET_AND_BC;
    wire wr2 = reg_wr_in && reg_addr_in == ADDR_OUTPUT_STATE;
    property p_addr_prog;
        wr0 && reg_wdata_in[0] |-> ##3 active_address_out == $past(reg_wdata_in[7:1], 3);
    endproperty
    a_addr_prog: assert property (p_addr_prog) else $error("programmed address lost");
    property p_addr_strap;
        wr0 && !reg_wdata_in[0] |-> ##3 active_address_out == $past(address_strap_input_in);
    endproperty
    a_addr_strap: assert property (p_addr_strap) else $error("strap address lost");
    property p_rc_pass;
        pass_through_a_in || pass_through_b_in |=> return_channel_active_out;
    endproperty
    a_rc_pass: assert property (p_rc_pass) else $error("return channel dropped");
    property p_remote_keep;
        wr1 && reg_remote_in && !reg_wdata_in[2] && return_channel_active_out
            |-> ##3 return_channel_active_out;
    endproperty
    a_remote_keep: assert property (p_remote_keep) else $error("remote cleared enable");
    property p_reset_len;
        wr1 && (reg_wdata_in[1] || reg_wdata_in[0]) |-> ##[1:4] $rose(logic_reset_out)
            ##0 logic_reset_out[*4] ##1 !logic_reset_out;
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("reset pulse length");
    property p_oe;
        wr2 |-> ##3 eff_output_enable_out == ($past(reg_wdata_in[OVERRIDE_BIT], 3) ?
            $past(reg_wdata_in[OUTPUT_ENABLE_BIT], 3) : DEFAULT_OUTPUT_ENABLE);
    endproperty
    a_oe: assert property (p_oe) else $error("output enable wrong");
    property p_sleep;
        wr2 |-> ##3 eff_sleep_state_out == ($past(reg_wdata_in[OVERRIDE_BIT], 3) ?
            $past(reg_wdata_in[SLEEP_STATE_VALUE_BIT], 3) : DEFAULT_SLEEP_STATE);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep state wrong");
    property p_osc_lock;
        link_lock_in |=> !pixel_clk_sel_osc_out;
    endproperty
    a_osc_lock: assert property (p_osc_lock) else $error("fallback clock while locked");
    property p_rd_rsv;
        reg_rd_in && reg_addr_in == ADDR_RESET_AND_BC |-> ##3 (reg_rdata_out & 8'hFB) == 8'h00;
    endproperty
    a_rd_rsv: assert property (p_rd_rsv) else $error("reserved bits set");
endmodule
bind dir_regs dir_regs_assertions dir_regs_assertions_inst (.clk_sys_in, .rst_in, .clk_en_in,
    .address_strap_input_in, .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in,
    .reg_remote_in, .reg_rdata_out, .pass_through_a_in, .pass_through_b_in, .link_lock_in,
    .active_address_out, .return_channel_active_out, .logic_reset_out,
    .eff_output_enable_out, .eff_sleep_state_out, .pixel_clk_sel_osc_out);

// ==== sim/dir_regs_test.sv ====
// testbench: identity, reset and output-state registers driven through the host model
`timescale 1ns/1ps
module dir_regs_test
    import dir_pkg::*;
;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic [6:0] strap = 7'h1A;
    logic pa = 1'b0;
    logic pb = 1'b0;
    logic lock = 1'b1;
    logic osc = 1'b1;
    logic pix = 1'b0;
    logic en = 1'b1;
    logic wr, rd, rem, rca, lrst, eoe, esl, sel, pco;
    logic [7:0] addr, wd, rdat, d;
    logic [6:0] act;
    int bad_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int n;
    // rows: remote, offset, write data, expected read-back
    logic [24:0] rows [9] = '{{1'b0, 8'h02, 8'hFF, 8'hF0}, {1'b0, 8'h02, 8'h5A, 8'h50},
        {1'b0, 8'h00, 8'h35, 8'h35}, {1'b0, 8'h00, 8'hA4, 8'hA4}, {1'b0, 8'h01, 8'h00, 8'h00},
        {1'b1, 8'h01, 8'h04, 8'h04}, {1'b1, 8'h01, 8'h00, 8'h04}, {1'b0, 8'h01, 8'h04, 8'h04},
        {1'b0, 8'h07, 8'hFF, 8'h00}};
    always #12.5 clk_sys_in = ~clk_sys_in;
    dir_host_model dir_host_model_inst (.clk_sys_in(clk_sys_in), .reg_rdata_in(rdat),
        .reg_wr_out(wr), .reg_rd_out(rd), .reg_addr_out(addr), .reg_wdata_out(wd),
        .reg_remote_out(rem));
    dir_regs dir_regs_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .clk_en_in(en),
        .address_strap_input_in(strap), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
        .reg_wdata_in(wd), .reg_remote_in(rem), .reg_rdata_out(rdat),
        .pass_through_a_in(pa), .pass_through_b_in(pb), .link_lock_in(lock),
        .osc_clk_in(osc), .pixel_clk_in(pix), .active_address_out(act),
        .return_channel_active_out(rca), .logic_reset_out(lrst),
        .eff_output_enable_out(eoe), .eff_sleep_state_out(esl),
        .pixel_clk_sel_osc_out(sel), .pixel_clk_out(pco));
    task automatic tally_and_finish();
        if (bad_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask
    // reset request written while the pulse is counted alongside
    task automatic pulse(input logic [7:0] v);
        n = 0;
        fork
            dir_host_model_inst.wr(ADDR_RESET_AND_BC, v, 1'b0);
            repeat (12) @(negedge clk_sys_in) n += int'(lrst);
        join
        chk8(8'(n), {5'h00, DIGITAL_RESET_CYCLES});
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        dir_host_model_inst.rd(a, d);
        chk8(d, e);
    endtask
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (5) @(negedge clk_sys_in);
        rst_in = 1'b0;
        rdchk(ADDR_OWN_BUS_ADDRESS, {strap, 1'b0});
        rdchk(ADDR_RESET_AND_BC, 8'h04);
        rdchk(ADDR_OUTPUT_STATE, 8'h00);
        chk1(eoe, DEFAULT_OUTPUT_ENABLE);
        chk1(esl, DEFAULT_SLEEP_STATE);
        chk8({1'b0, act}, {1'b0, strap});
        foreach (rows[i]) begin
            dir_host_model_inst.wr(rows[i][23:16], rows[i][15:8], rows[i][24]);
            rdchk(rows[i][23:16], rows[i][7:0]);
        end
        // enable cleared: pass-through bits alone keep the channel up
        dir_host_model_inst.wr(ADDR_RESET_AND_BC, 8'h00, 1'b0);
        for (n = 0; n < 4; n++) begin
            {pa, pb} = 2'(n);
            repeat (3) @(negedge clk_sys_in);
            chk1(rca, pa | pb);
        end
        for (int i = 0; i < 8; i++) begin
            dir_host_model_inst.wr(ADDR_OUTPUT_STATE, {i[2], i[1], 1'b0, i[0], 4'h0}, 1'b0);
            repeat (2) @(negedge clk_sys_in);
            chk1(eoe, i[1] ? i[2] : 1'b1);
            chk1(esl, i[1] ? i[0] : 1'b1);
        end
        dir_host_model_inst.raise_oe(8'hC0);
        chk1(eoe, 1'b1);
        dir_host_model_inst.wr(ADDR_OUTPUT_STATE, 8'h20, 1'b0);
        lock = 1'b0;
        repeat (3) @(negedge clk_sys_in);
        chk1(sel, 1'b1);
        chk1(pco, osc);
        lock = 1'b1;
        repeat (3) @(negedge clk_sys_in);
        chk1(sel, 1'b0);
        chk1(pco, pix);
        // frozen clock enable: a write issued meanwhile must not land
        en = 1'b0;
        dir_host_model_inst.wr(ADDR_OUTPUT_STATE, 8'hF0, 1'b0);
        en = 1'b1;
        rdchk(ADDR_OUTPUT_STATE, 8'h20);
        chk1(eoe, 1'b1);
        // logic-only reset must spare every register value
        dir_host_model_inst.wr(ADDR_OWN_BUS_ADDRESS, 8'h35, 1'b0);
        dir_host_model_inst.wr(ADDR_OUTPUT_STATE, 8'hD0, 1'b0);
        dir_host_model_inst.wr(ADDR_RESET_AND_BC, 8'h00, 1'b0);
        pulse(8'h01);
        rdchk(ADDR_OWN_BUS_ADDRESS, 8'h35);
        rdchk(ADDR_RESET_AND_BC, 8'h00);
        rdchk(ADDR_OUTPUT_STATE, 8'hD0);
        chk8({1'b0, act}, 8'h1A);
        // full reset reloads the power-up strap, not the new value on the pins
        strap = 7'h2B;
        pulse(8'h02);
        rdchk(ADDR_OWN_BUS_ADDRESS, {7'h1A, 1'b0});
        rdchk(ADDR_RESET_AND_BC, 8'h04);
        rdchk(ADDR_OUTPUT_STATE, 8'h00);
        chk8({1'b0, act}, {1'b0, strap});
        // a second power-up reset takes the strap now on the pins
        rst_in = 1'b1;
        repeat (2) @(negedge clk_sys_in);
        rst_in = 1'b0;
        rdchk(ADDR_OWN_BUS_ADDRESS, {strap, 1'b0});
        rdchk(ADDR_RESET_AND_BC, 8'h04);
        tally_and_finish();
    end
endmodule
